// ===== rtl/rad_defines.svh
// offsets, fields and reset values of the record gain and activity block
`ifndef RAD_DEFINES_SVH
`define RAD_DEFINES_SVH

// register byte offsets
`define RAD_OFF_ACT_CTRL      12'h000
`define RAD_OFF_ACT_CFG       12'h004
`define RAD_OFF_DET_CFG       12'h008
`define RAD_OFF_AGC_LEVEL     12'h00C
`define RAD_OFF_AGC_TIME      12'h010
`define RAD_OFF_MAN_GAIN      12'h014
`define RAD_OFF_IRQ_STAT      12'h018
`define RAD_OFF_IRQ_MASK      12'h01C
`define RAD_OFF_STATUS        12'h020

// control field positions
`define RAD_BIT_AGC_EN        0
`define RAD_BIT_VOICE_EN      2
`define RAD_BIT_ULTRA_EN      3
`define RAD_MODE_HI           7
`define RAD_MODE_LO           6
`define RAD_CHSEL_HI          5
`define RAD_CHSEL_LO          4

// alert mode codes
`define RAD_ALERT_IRQ         2'h1
`define RAD_ALERT_WAKE        2'h2

// interrupt status bits
`define RAD_IRQ_VOICE         0
`define RAD_IRQ_ULTRA         1
`define RAD_IRQ_W             2

// reset values
`define RAD_RST_ACT_CTRL      4'h0
`define RAD_RST_ACT_CFG       8'h00
`define RAD_RST_DET_THR       8'h20
`define RAD_RST_DET_HOLD      8'h04
`define RAD_RST_AGC_TARGET    8'h40
`define RAD_RST_AGC_MAXGAIN   8'h50
`define RAD_RST_AGC_NOISE     8'h04
`define RAD_RST_AGC_ATTACK    16'h0010
`define RAD_RST_AGC_RELEASE   16'h0100
`define RAD_RST_MAN_GAIN      8'h00

`endif

// ===== rtl/rad_pkg.sv
// types shared by the record gain / activity detection block
package rad_pkg;

    // one audio sample with its strobe
    typedef struct packed {
        logic               valid;
        logic signed [15:0] data;
    } rad_sample_t;

    // detector settings
    typedef struct packed {
        logic [7:0] hold;
        logic [7:0] thr;
    } rad_det_cfg_t;

    // automatic gain settings
    typedef struct packed {
        logic [15:0] release_time;
        logic [15:0] attack_time;
        logic [7:0]  noise;
        logic [7:0]  max_gain;
        logic [7:0]  target;
    } rad_agc_cfg_t;

    // low power activity sequencer
    typedef enum logic [1:0] {
        RAD_IDLE,
        RAD_MONITOR,
        RAD_RECORD
    } rad_lp_state_t;

endpackage

// ===== rtl/rad_activity_detect.sv
// voice and ultrasonic activity detector on one selected channel
`timescale 1ns/100ps
`include "rad_defines.svh"

module rad_activity_detect (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 voice_en,
    input  wire logic                 ultra_en,
    input  rad_pkg::rad_sample_t      sample,
    input  rad_pkg::rad_det_cfg_t     cfg,
    output logic [1:0]                hit
);

    logic signed [15:0] prev_q;
    logic [15:0]        diff;
    logic [7:0]         metric [2];
    logic [1:0]         path_en;

    // magnitude of a 16-bit value reduced to its top 8 bits
    function automatic logic [7:0] mag8(input logic [15:0] v);
        logic [15:0] a;
        a = v[15] ? (~v + 16'h0001) : v;
        return a[15] ? 8'hFF : a[14:7];
    endfunction

    // ----
    // signal metrics
    // ----
    // first difference acts as a crude high band filter for ultrasonic energy
    assign diff      = sample.data - prev_q;
    assign metric[0] = mag8(sample.data);       // [R1]
    assign metric[1] = mag8(diff);              // [R3]
    assign path_en   = {ultra_en, voice_en};

    // previous sample for the difference path
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_q <= 16'sh0000;
        end else if (sample.valid) begin
            prev_q <= sample.data;
        end
    end

    // ----
    // per path run-length detectors
    // ----
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_path
            logic [7:0] run_q;
            logic       hit_q;
            // a single loud sample triggers only when hold is 0; otherwise the level must hold for a run of hold+1 samples
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    run_q <= 8'h00;
                    hit_q <= 1'b0;
                end else begin
                    hit_q <= 1'b0;
                    if (!path_en[g]) begin
                        run_q <= 8'h00;
                    end else if (sample.valid) begin
                        if (metric[g] > cfg.thr) begin
                            if (run_q >= cfg.hold) begin
                                hit_q <= 1'b1;                // [R1] [R3]
                                run_q <= 8'h00;
                            end else begin
                                run_q <= run_q + 8'h01;
                            end
                        end else begin
                            run_q <= 8'h00;
                        end
                    end
                end
            end
            assign hit[g] = hit_q;
        end
    endgenerate

endmodule // rad_activity_detect

// ===== rtl/rad_top.sv
// record path automatic gain control and low power activity detection, APB slave
//
// Contract
// [R1] voice mode watches one selected channel nonstop for voice; the detector here stops once a wake enters RECORD.
// [R2] voice_detect_enable (bit 2) set to one enters voice mode.
// [R3] ultrasonic mode watches one selected channel nonstop for ultrasonic energy; the detector here stops once a wake enters RECORD.
// [R4] ultrasonic_detect_enable (bit 3) set to one enters ultrasonic mode.
// [R5] activity_alert_mode bits 7:6 pick interrupt or wake and record.
// [R6] activity_channel_select bits 5:4 pick the watched channel.
// [R7] analog and digital microphone channels both feed the detector.
// [R8] automatic gain on: hardware sets gain, not the manual value.
// [R9] gain uses target, maximum gain, attack, release and noise threshold.
// [R10] host leaves headroom in the target level against clipping.
// [R11] alert mode 1 is interrupt, 2 is wake, 0 and 3 disabled.
`timescale 1ns/100ps
`include "rad_defines.svh"

module rad_top (
    input  wire logic            pclk,
    input  wire logic            presetn,
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [11:0]     paddr,
    input  wire logic [31:0]     pwdata,
    input  wire logic [3:0]      pstrb,
    output logic [31:0]          prdata,
    output logic                 pready,
    output logic                 pslverr,
    input  rad_pkg::rad_sample_t analog_in,
    input  rad_pkg::rad_sample_t dmic_in [3],
    output logic [7:0]           channel_gain,
    output logic                 agc_active,
    output logic                 record_active,
    output logic                 irq
);

    // ----
    // register storage
    // ----
    logic [3:0]              ctrl_q;
    logic [7:0]              cfg_q;
    rad_pkg::rad_det_cfg_t   det_q;
    rad_pkg::rad_agc_cfg_t   agc_q;
    logic [7:0]              man_gain_q;
    logic [`RAD_IRQ_W-1:0]   irq_stat_q;
    logic [`RAD_IRQ_W-1:0]   irq_mask_q;
    logic [31:0]             prdata_q;

    logic [7:0]              gain_q;
    logic [15:0]             atk_cnt_q;
    logic [15:0]             rel_cnt_q;
    rad_pkg::rad_lp_state_t  state_q;
    rad_pkg::rad_lp_state_t  state_d;

    logic                    wr_en;
    logic                    rd_en;
    logic [3:0]              wr_sel;
    logic [3:0]              rd_sel;
    logic                    voice_en;
    logic                    ultra_en;
    logic [1:0]              alert_mode;
    logic [1:0]              ch_sel;
    logic                    monitoring;
    rad_pkg::rad_sample_t    watch_smp;
    logic [1:0]              hit;
    logic                    any_hit;
    logic [7:0]              peak;
    logic [31:0]             rd_mux;

    // ----
    // address decode
    // ----
    // index 0 means unmapped; shared by the read and the write path
    function automatic logic [3:0] reg_index(input logic [11:0] a);
        if (a == `RAD_OFF_ACT_CTRL) begin
            return 4'h1;
        end else if (a == `RAD_OFF_ACT_CFG) begin
            return 4'h2;
        end else if (a == `RAD_OFF_DET_CFG) begin
            return 4'h3;
        end else if (a == `RAD_OFF_AGC_LEVEL) begin
            return 4'h4;
        end else if (a == `RAD_OFF_AGC_TIME) begin
            return 4'h5;
        end else if (a == `RAD_OFF_MAN_GAIN) begin
            return 4'h6;
        end else if (a == `RAD_OFF_IRQ_STAT) begin
            return 4'h7;
        end else if (a == `RAD_OFF_IRQ_MASK) begin
            return 4'h8;
        end else if (a == `RAD_OFF_STATUS) begin
            return 4'h9;
        end else begin
            return 4'h0;
        end
    endfunction

    // magnitude of a sample, top 8 bits
    function automatic logic [7:0] level8(input logic [15:0] v);
        logic [15:0] a;
        a = v[15] ? (~v + 16'h0001) : v;
        return a[15] ? 8'hFF : a[14:7];
    endfunction

    // zero wait state slave; unmapped addresses answer with pslverr
    assign pready  = 1'b1;
    assign wr_en   = psel & penable & pwrite;
    assign rd_en   = psel & penable & ~pwrite;
    assign wr_sel  = wr_en ? reg_index(paddr) : 4'h0;
    assign rd_sel  = reg_index(paddr);
    assign pslverr = psel & penable & (rd_sel == 4'h0);
    assign prdata  = prdata_q;

    // ----
    // control fields
    // ----
    assign voice_en   = ctrl_q[`RAD_BIT_VOICE_EN];                  // [R2]
    assign ultra_en   = ctrl_q[`RAD_BIT_ULTRA_EN];                  // [R4]
    assign alert_mode = cfg_q[`RAD_MODE_HI:`RAD_MODE_LO];           // [R5]
    assign ch_sel     = cfg_q[`RAD_CHSEL_HI:`RAD_CHSEL_LO];         // [R6]
    assign agc_active = ctrl_q[`RAD_BIT_AGC_EN];

    // control register, byte lane 0 only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `RAD_RST_ACT_CTRL;
        end else if (wr_sel == 4'h1 && pstrb[0]) begin
            ctrl_q <= pwdata[3:0];                                  // [R2] [R4]
        end
    end

    // alert and channel configuration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= `RAD_RST_ACT_CFG;
        end else if (wr_sel == 4'h2 && pstrb[0]) begin
            cfg_q <= {pwdata[7:4], 4'h0};
        end
    end

    // detector settings
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            det_q.thr  <= `RAD_RST_DET_THR;
            det_q.hold <= `RAD_RST_DET_HOLD;
        end else if (wr_sel == 4'h3) begin
            if (pstrb[0]) begin
                det_q.thr <= pwdata[7:0];
            end
            if (pstrb[1]) begin
                det_q.hold <= pwdata[15:8];
            end
        end
    end

    // gain algorithm parameters
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            agc_q.target       <= `RAD_RST_AGC_TARGET;
            agc_q.max_gain     <= `RAD_RST_AGC_MAXGAIN;
            agc_q.noise        <= `RAD_RST_AGC_NOISE;
            agc_q.attack_time  <= `RAD_RST_AGC_ATTACK;
            agc_q.release_time <= `RAD_RST_AGC_RELEASE;
        end else if (wr_sel == 4'h4) begin
            if (pstrb[0]) begin
                agc_q.target <= pwdata[7:0];                        // [R9]
            end
            if (pstrb[1]) begin
                agc_q.max_gain <= pwdata[15:8];                     // [R9]
            end
            if (pstrb[2]) begin
                agc_q.noise <= pwdata[23:16];                       // [R9]
            end
        end else if (wr_sel == 4'h5) begin
            if (pstrb[0] && pstrb[1]) begin
                agc_q.attack_time <= pwdata[15:0];                  // [R9]
            end
            if (pstrb[2] && pstrb[3]) begin
                agc_q.release_time <= pwdata[31:16];                // [R9]
            end
        end
    end

    // manual gain, used while the automatic loop is off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            man_gain_q <= `RAD_RST_MAN_GAIN;
        end else if (wr_sel == 4'h6 && pstrb[0]) begin
            man_gain_q <= pwdata[7:0];
        end
    end

    // ----
    // channel selection and detection
    // ----
    // code 0 is the analog channel, 1..3 the digital microphones
    always_comb begin
        if (ch_sel == 2'h0) begin
            watch_smp = analog_in;                                  // [R6] [R7]
        end else begin
            watch_smp = dmic_in[ch_sel - 2'h1];                     // [R6] [R7]
        end
    end

    // detector only runs while monitoring, so counts restart on each entry
    assign monitoring = (state_q == rad_pkg::RAD_MONITOR);

    rad_activity_detect u_detect (
        .pclk     (pclk),
        .presetn  (presetn),
        .voice_en (monitoring & voice_en),
        .ultra_en (monitoring & ultra_en),
        .sample   (watch_smp),
        .cfg      (det_q),
        .hit      (hit)
    );

    assign any_hit = |hit;

    // ----
    // low power sequencer
    // ----
    // wake latches recording on; only dropping both enables returns to idle
    always_comb begin
        state_d = state_q;
        case (state_q)
            rad_pkg::RAD_IDLE: begin
                if (voice_en || ultra_en) begin
                    state_d = rad_pkg::RAD_MONITOR;                 // [R2] [R4]
                end
            end
            rad_pkg::RAD_MONITOR: begin
                if (!voice_en && !ultra_en) begin
                    state_d = rad_pkg::RAD_IDLE;
                end else if (any_hit && alert_mode == `RAD_ALERT_WAKE) begin
                    state_d = rad_pkg::RAD_RECORD;                  // [R5] [R11]
                end
            end
            rad_pkg::RAD_RECORD: begin
                if (!voice_en && !ultra_en) begin
                    state_d = rad_pkg::RAD_IDLE;
                end
            end
            default: begin
                state_d = rad_pkg::RAD_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= rad_pkg::RAD_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    assign record_active = (state_q == rad_pkg::RAD_RECORD);

    // ----
    // interrupt status and mask
    // ----
    // a detection in the clearing cycle survives: set wins over write-one-clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_q <= {`RAD_IRQ_W{1'b0}};
        end else begin
            irq_stat_q <= (irq_stat_q
                           & ~((wr_sel == 4'h7 && pstrb[0]) ? pwdata[1:0] : 2'h0))
                          | ((monitoring && alert_mode == `RAD_ALERT_IRQ) ? hit : 2'h0); // [R5] [R11]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_q <= {`RAD_IRQ_W{1'b0}};
        end else if (wr_sel == 4'h8 && pstrb[0]) begin
            irq_mask_q <= pwdata[1:0];
        end
    end

    assign irq = |(irq_stat_q & irq_mask_q);

    // ----
    // automatic gain loop
    // ----
    // the record channel is measured after gain, so the loop closes outside
    assign peak = level8(analog_in.data);

    // attack lowers gain fast on loud input; release raises it slowly on weak input
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gain_q    <= `RAD_RST_MAN_GAIN;
            atk_cnt_q <= 16'h0000;
            rel_cnt_q <= 16'h0000;
        end else if (!agc_active) begin
            gain_q    <= man_gain_q;                                // [R8]
            atk_cnt_q <= 16'h0000;
            rel_cnt_q <= 16'h0000;
        end else if (analog_in.valid) begin
            if (peak > agc_q.target) begin
                rel_cnt_q <= 16'h0000;
                if (atk_cnt_q >= agc_q.attack_time) begin
                    atk_cnt_q <= 16'h0000;
                    if (gain_q != 8'h00) begin
                        gain_q <= gain_q - 8'h01;                   // [R8] [R9]
                    end
                end else begin
                    atk_cnt_q <= atk_cnt_q + 16'h0001;
                end
            end else if (peak < agc_q.target && peak > agc_q.noise) begin
                atk_cnt_q <= 16'h0000;
                if (rel_cnt_q >= agc_q.release_time) begin
                    rel_cnt_q <= 16'h0000;
                    if (gain_q < agc_q.max_gain) begin
                        gain_q <= gain_q + 8'h01;                   // [R8] [R9]
                    end
                end else begin
                    rel_cnt_q <= rel_cnt_q + 16'h0001;
                end
            end else begin
                // below the noise floor, hold gain so hiss is not amplified
                atk_cnt_q <= 16'h0000;
                rel_cnt_q <= 16'h0000;
            end
        end
    end

    assign channel_gain = gain_q;

    // ----
    // read data
    // ----
    always_comb begin
        if (rd_sel == 4'h1) begin
            rd_mux = {28'h0000000, ctrl_q};
        end else if (rd_sel == 4'h2) begin
            rd_mux = {24'h000000, cfg_q};
        end else if (rd_sel == 4'h3) begin
            rd_mux = {16'h0000, det_q.hold, det_q.thr};
        end else if (rd_sel == 4'h4) begin
            rd_mux = {8'h00, agc_q.noise, agc_q.max_gain, agc_q.target};
        end else if (rd_sel == 4'h5) begin
            rd_mux = {agc_q.release_time, agc_q.attack_time};
        end else if (rd_sel == 4'h6) begin
            rd_mux = {24'h000000, man_gain_q};
        end else if (rd_sel == 4'h7) begin
            rd_mux = {30'h00000000, irq_stat_q};
        end else if (rd_sel == 4'h8) begin
            rd_mux = {30'h00000000, irq_mask_q};
        end else if (rd_sel == 4'h9) begin
            rd_mux = {21'h000000, record_active, state_q, gain_q};
        end else begin
            rd_mux = 32'h00000000;
        end
    end

    // read data registered in the setup cycle, valid in the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            prdata_q <= rd_mux;
        end
    end

endmodule // rad_top

// ===== verification/rad_top_monitor.sv
// assertion checker for the record gain and activity detection block
`timescale 1ns/100ps
module rad_top_monitor (
    input  wire logic           pclk,
    input  wire logic           presetn,
    input  wire logic           psel,
    input  wire logic           penable,
    input  wire logic           pwrite,
    input  wire logic [11:0]    paddr,
    input  wire logic [31:0]    pwdata,
    input  wire logic [3:0]     pstrb,
    input  wire logic           pready,
    input  wire logic           pslverr,
    input  rad_pkg::rad_sample_t analog_in,
    input  rad_pkg::rad_sample_t dmic_in [3],
    input  wire logic [7:0]     channel_gain,
    input  wire logic           agc_active,
    input  wire logic           record_active,
    input  wire logic           irq
);
    // ----
    // helpers
    // ----
    logic acc_wr;
    logic smp;
    // low byte lane write in the access phase
    assign acc_wr = psel & penable & pwrite & pstrb[0];
    // any strobe; a hit can only follow one of these
    assign smp = analog_in.valid | dmic_in[0].valid | dmic_in[1].valid | dmic_in[2].valid;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ----
    // properties
    // ----
    property p_ready; pready; endproperty
    property p_err; psel && penable && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 12'h020); endproperty
    property p_agc_on; acc_wr && paddr == 12'h000 |=> agc_active == $past(pwdata[0]); endproperty
    property p_man; acc_wr && paddr == 12'h014 && !agc_active ##1 !agc_active
        |=> channel_gain == $past(pwdata[7:0], 2); endproperty
    property p_rec_off; acc_wr && paddr == 12'h000 && pwdata[3:2] == 2'h0 |-> ##2 !record_active;
    endproperty
    property p_mask0; acc_wr && paddr == 12'h01C && pwdata[1:0] == 2'h0 |=> !irq; endproperty
    property p_irq_src; $rose(irq) |-> $past(acc_wr && paddr == 12'h01C) || $past(smp, 2);
    endproperty
    property p_rec_src; $rose(record_active) |-> $past(smp, 2); endproperty
    a_ready: assert property (p_ready) else $error("ready low");
    a_err: assert property (p_err) else $error("error response wrong");
    a_agc_on: assert property (p_agc_on) else $error("gain mode flag wrong");
    a_man: assert property (p_man) else $error("manual gain not applied");
    a_rec_off: assert property (p_rec_off) else $error("record not left");
    a_mask0: assert property (p_mask0) else $error("masked interrupt high");
    a_irq_src: assert property (p_irq_src) else $error("interrupt without sample");
    a_rec_src: assert property (p_rec_src) else $error("wake without sample");
    c_irq: cover property ($rose(irq));
    c_rec: cover property ($rose(record_active));
    c_agc: cover property ($rose(agc_active));
    c_err: cover property (pslverr);
endmodule // rad_top_monitor

bind rad_top rad_top_monitor i_mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .pready, .pslverr, .analog_in, .dmic_in, .channel_gain, .agc_active,
    .record_active, .irq);

// ===== verification/rad_mic_model.sv
// microphone source model: one analog and three digital channels
`timescale 1ns/100ps
module rad_mic_model (
    input  wire logic            pclk,
    input  wire logic            presetn,
    input  wire logic [1:0]      chan,
    input  wire logic [15:0]     level,
    input  wire logic            alt,
    output rad_pkg::rad_sample_t analog_out,
    output rad_pkg::rad_sample_t dmic_out [3]
);
    logic [1:0]         tick_q;
    logic               sign_q;
    logic signed [15:0] val;
    // alternating sign puts all energy at the top of the band
    assign val = (alt && sign_q) ? -$signed(level) : $signed(level);
    // one sample strobe every four clocks on all channels
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_q <= 2'h0;
            sign_q <= 1'b0;
        end else begin
            tick_q <= tick_q + 2'h1;
            if (tick_q == 2'h3) begin
                sign_q <= !sign_q;
            end
        end
    end
    // only the chosen channel speaks; the other mics stay quiet, not stale
    always_comb begin
        analog_out = '{valid: tick_q == 2'h3, data: (chan == 2'h0) ? val : 16'sh0000};
        for (int i = 0; i < 3; i++) begin
            dmic_out[i] = '{valid: tick_q == 2'h3, data: (chan == 2'(i + 1)) ? val : 16'sh0000};
        end
    end
endmodule // rad_mic_model

// ===== verification/test_record_agc_activity_detect.sv
// self-checking bench for the record gain and activity detection block
`timescale 1ns/100ps
module test_record_agc_activity_detect;
    logic                 pclk = 1'b0;
    logic                 presetn;
    logic                 psel, penable, pwrite, pready, pslverr, er, m_alt;
    logic [11:0]          paddr;
    logic [31:0]          pwdata, prdata, rd;
    logic [3:0]           pstrb;
    rad_pkg::rad_sample_t analog_in;
    rad_pkg::rad_sample_t dmic_in [3];
    logic [7:0]           channel_gain;
    logic                 agc_active, record_active, irq;
    logic [1:0]           m_chan;
    logic [15:0]          m_level;
    int                   n_errors = 0;
    int                   checked = 0;

    rad_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .analog_in, .dmic_in, .channel_gain, .agc_active,
        .record_active, .irq);
    rad_mic_model i_mic (.pclk, .presetn, .chan(m_chan), .level(m_level), .alt(m_alt),
        .analog_out(analog_in), .dmic_out(dmic_in));

    always #2 pclk = ~pclk;

    // ----
    // helpers
    // ----
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // setup, then access until ready; idle edge first avoids double drives
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (k == 50) begin
            n_errors++;
            tally_and_finish();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic mic(input logic [1:0] c, input logic [15:0] l, input logic a);
        m_chan <= c;
        m_level <= l;
        m_alt <= a;
    endtask
    task automatic run(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // ----
    // scenarios
    // ----
    task automatic t_regs;
        rdc(12'h008, 32'h0000_0420);
        rdc(12'h00C, 32'h0004_5040);
        rdc(12'h010, 32'h0100_0010);
        rdc(12'h000, 32'h0);
        wr(12'h004, 32'hFF);
        rdc(12'h004, 32'hF0);
        wr(12'h020, 32'hFFFF_FFFF);
        rdc(12'h020, 32'h0);
        apb(1'b0, 12'h024, 32'h0);
        chk(er, 32'h1);
    endtask
    // loud source on the neighbour channel must go unheard
    task automatic t_chan;
        for (int c = 0; c < 4; c++) begin
            wr(12'h004, 32'h40 | (c << 4));
            wr(12'h000, 32'h4);
            mic(2'(c + 1), 16'h3000, 1'b0);
            run(100);
            rdc(12'h018, 32'h0);
            mic(2'(c), 16'h3000, 1'b0);
            run(100);
            rdc(12'h018, 32'h1);
            chk(irq, 32'h0);
            wr(12'h000, 32'h0);
            wr(12'h018, 32'h3);
        end
    endtask
    // every alert code: only 1 interrupts, only 2 wakes
    task automatic t_modes;
        for (int m = 0; m < 4; m++) begin
            wr(12'h01C, 32'h1);
            wr(12'h004, m << 6);
            mic(2'h0, 16'h3000, 1'b0);
            wr(12'h000, 32'h4);
            run(100);
            chk(irq, m == 1);
            chk(record_active, m == 2);
            wr(12'h000, 32'h0);
            wr(12'h018, 32'h3);
            run(1); // clear lands on the last edge; look once it has settled
            chk({irq, record_active}, 32'h0);
        end
    endtask
    task automatic t_ultra;
        wr(12'h01C, 32'h2);
        wr(12'h004, 32'h40);
        wr(12'h000, 32'h8);
        run(100);
        chk(irq, 32'h0);
        mic(2'h0, 16'h3000, 1'b1);
        run(100);
        rdc(12'h018, 32'h2);
        chk(irq, 32'h1);
        wr(12'h000, 32'h0);
        wr(12'h018, 32'h2);
        mic(2'h0, 16'h0000, 1'b0);
    endtask
    // short attack and release so steps come every few samples
    task automatic t_agc;
        wr(12'h014, 32'h33);
        run(3);
        chk(channel_gain, 32'h33);
        wr(12'h010, 32'h0001_0001);
        wr(12'h00C, 32'h0004_3640);
        mic(2'h0, 16'h6000, 1'b0);
        wr(12'h000, 32'h1);
        run(1);
        chk(agc_active, 32'h1);
        run(60);
        chk(channel_gain < 8'h33, 32'h1);
        mic(2'h0, 16'h1000, 1'b0);
        run(600);
        chk(channel_gain, 32'h36);
        wr(12'h000, 32'h0);
        run(3);
        chk(channel_gain, 32'h33);
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hF;
        m_chan = 2'h0;
        m_level = 16'h0000;
        m_alt = 1'b0;
        run(2);
        presetn <= 1'b1;
        t_regs();
        t_chan();
        t_modes();
        t_ultra();
        t_agc();
        tally_and_finish();
    end
endmodule // test_record_agc_activity_detect
